// ---- fapc_pkg.sv ----
package fapc_pkg;
  // Flash organisation
  localparam int FAPC_NUM_MODULES     = 4;
  localparam int FAPC_ADDR_W          = 20;
  localparam int FAPC_DATA_W          = 32;
  localparam int FAPC_WS_W            = 4;
  localparam int FAPC_MOD_W           = 2;
  // Module that may always be written while others are read
  localparam logic [1:0] FAPC_FREE_MODULE = 2'h3;
  // Parallel limits
  localparam int FAPC_PAR_LIMIT_ONE_RD  = 4;
  localparam int FAPC_PAR_LIMIT_MANY_RD = 1;
  // Clock and timing
  localparam int FAPC_CLK_MHZ         = 250;
  localparam int FAPC_FAST_LIMIT_MHZ  = 80;
  localparam int FAPC_ERASE_US        = 7000;  // Typical erase, below 8.0 ms maximum
  localparam int FAPC_PROG_US         = 3000;  // Typical program, below 3.5 ms maximum
  localparam int FAPC_ERASE_CYC       = FAPC_ERASE_US * FAPC_CLK_MHZ;
  localparam int FAPC_PROG_CYC        = FAPC_PROG_US * FAPC_CLK_MHZ;
  localparam int FAPC_SM_OVERHEAD     = 4;     // Sequencer overhead cycles
  localparam int FAPC_CNT_W           = 24;
  localparam logic [FAPC_WS_W-1:0] FAPC_WS_RESET = 4'h4;
  // Word address step for sequential detection
  localparam logic [FAPC_ADDR_W-1:0] FAPC_ADDR_STEP = 20'h00001;

  typedef enum logic [1:0] {FAPC_OP_NONE, FAPC_OP_ERASE, FAPC_OP_PROG} fapc_op_t;

  typedef struct packed {
    logic                   valid;
    logic [FAPC_MOD_W-1:0]  module_sel;
    logic [FAPC_ADDR_W-1:0] addr;
  } fapc_rd_req_t;

  typedef struct packed {
    logic                   start;
    fapc_op_t               op;
    logic [FAPC_NUM_MODULES-1:0] modules;
  } fapc_pe_req_t;
endpackage

// ---- fapc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - Software sets wait states: 1 to 8 MHz, 2 to 13, 3 to 17, 4 above.
// R2 - Configured wait states are inserted only on non-sequential reads.
// R3 - Prefetch next word so sequential reads are served without wait states.
// R4 - Never erase or program a module that is currently being read.
// R5 - One read module or SRAM and clock up to 80 MHz allows four parallel.
// R6 - Reads from several modules allow one at a time; module 3 always allowed.
// R7 - Erase completes within 8.0 ms, busy held throughout.
// R8 - Page program completes within 3.5 ms, busy held throughout.
// R9 - Durations come from a flash time base plus a few sequencer cycles.
// R10 - After delivery all sectors are erased and no protection is installed.
// R11 - Security pages may be erased at least ten times; software limits it.
// R12 - Refused program or erase requests are reported with an error flag; starts that arrive while busy are dropped without it.
module fapc_ctrl
  import fapc_pkg::*;
#(
  parameter int ERASE_CYC = FAPC_ERASE_CYC,
  parameter int PROG_CYC  = FAPC_PROG_CYC
)(
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic [FAPC_WS_W-1:0]        i_flash_wait_state_count,
  input  wire logic                        i_clk_le_80mhz,
  input  wire fapc_rd_req_t                i_rd_req,
  input  wire logic                        i_code_sram_rd,
  input  wire logic [FAPC_NUM_MODULES-1:0] i_read_modules,
  input  wire fapc_pe_req_t                i_pe_req,
  output logic                             o_rd_ready,
  output logic                             o_rd_seq_hit,
  output logic [FAPC_NUM_MODULES-1:0]      o_busy_modules,
  output logic                             o_busy,
  output logic                             o_pe_done,
  output logic                             o_pe_error
);

  typedef enum logic [1:0] {FAPC_ST_IDLE, FAPC_ST_RUN, FAPC_ST_TAIL} fapc_state_t;

  typedef struct packed {
    fapc_state_t                 state;
    logic [FAPC_CNT_W-1:0]       cnt;
    logic [FAPC_NUM_MODULES-1:0] busy_mods;
    logic                        busy;
    logic                        done;
    logic                        error;
    logic [FAPC_WS_W-1:0]        ws_cnt;
    logic                        rd_wait;
    logic [FAPC_ADDR_W-1:0]      pf_addr;
    logic                        pf_valid;
    logic                        rd_ready;
    logic                        seq_hit;
  } fapc_regs_t;

  fapc_regs_t st_r;
  fapc_regs_t st_nxt;

  // Population count of module mask
  function automatic logic [2:0] fapc_count(input logic [FAPC_NUM_MODULES-1:0] m);
    logic [2:0] c;
    c = 3'h0;
    for (int k = 0; k < FAPC_NUM_MODULES; k++)
    begin
      c = c + {2'h0, m[k]};
    end
    return c;
  endfunction

  logic [2:0] rd_cnt;
  logic [2:0] pe_cnt;
  logic       pe_allowed;
  logic       rd_seq;
  logic [FAPC_NUM_MODULES-1:0] rd_mask;

  // Permission check against current read activity
  always_comb
  begin
    rd_mask = i_read_modules;
    if (i_rd_req.valid)
    begin
      rd_mask[i_rd_req.module_sel] = 1'b1;
    end
    rd_cnt = fapc_count(rd_mask);
    pe_cnt = fapc_count(i_pe_req.modules);
    pe_allowed = (i_pe_req.modules != '0) && ((i_pe_req.modules & rd_mask) == '0); // R4
    if (rd_cnt <= 3'(FAPC_PAR_LIMIT_MANY_RD) && i_clk_le_80mhz)
    begin
      pe_allowed = pe_allowed && (pe_cnt <= 3'(FAPC_PAR_LIMIT_ONE_RD)); // R5
    end
    else
    begin
      pe_allowed = pe_allowed && ((pe_cnt <= 3'(FAPC_PAR_LIMIT_MANY_RD))
                   || (i_pe_req.modules == (4'h1 << FAPC_FREE_MODULE))); // R6
    end
    rd_seq = st_r.pf_valid && (i_rd_req.addr == st_r.pf_addr);
  end

  // Next-state: read wait states, prefetch and program/erase sequencer
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.rd_ready = 1'b0;
    st_nxt.seq_hit = 1'b0;
    // Reads: sequential hits from prefetch, others wait the configured count
    if (st_r.rd_wait)
    begin
      if (st_r.ws_cnt == '0)
      begin
        st_nxt.rd_wait = 1'b0;
        st_nxt.rd_ready = 1'b1;
      end
      else
      begin
        st_nxt.ws_cnt = st_r.ws_cnt - 4'h1;
      end
    end
    else if (i_rd_req.valid)
    begin
      st_nxt.pf_addr = i_rd_req.addr + FAPC_ADDR_STEP; // R3
      st_nxt.pf_valid = 1'b1;
      if (rd_seq)
      begin
        st_nxt.rd_ready = 1'b1; // R2
        st_nxt.seq_hit = 1'b1;
      end
      else
      begin
        st_nxt.rd_wait = 1'b1; // R2
        st_nxt.ws_cnt = i_flash_wait_state_count - 4'h1;
      end
    end
    // Sequencer
    case (st_r.state)
      FAPC_ST_IDLE:
      begin
        if (i_pe_req.start && i_pe_req.op != FAPC_OP_NONE)
        begin
          if (pe_allowed)
          begin
            st_nxt.state = FAPC_ST_RUN;
            st_nxt.busy_mods = i_pe_req.modules;
            st_nxt.busy = 1'b1;
            st_nxt.error = 1'b0;
            st_nxt.cnt = (i_pe_req.op == FAPC_OP_ERASE) ? FAPC_CNT_W'(ERASE_CYC - 1) // R7
                                                        : FAPC_CNT_W'(PROG_CYC - 1); // R8
          end
          else
          begin
            st_nxt.error = 1'b1; // R12
          end
        end
      end
      FAPC_ST_RUN:
      begin
        if (st_r.cnt == '0)
        begin
          st_nxt.state = FAPC_ST_TAIL;
          st_nxt.cnt = FAPC_CNT_W'(FAPC_SM_OVERHEAD - 1); // R9
        end
        else
        begin
          st_nxt.cnt = st_r.cnt - 24'h000001;
        end
      end
      FAPC_ST_TAIL:
      begin
        if (st_r.cnt == '0)
        begin
          st_nxt.state = FAPC_ST_IDLE;
          st_nxt.busy_mods = '0;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
        end
        else
        begin
          st_nxt.cnt = st_r.cnt - 24'h000001;
        end
      end
      default:
      begin
        st_nxt.state = FAPC_ST_IDLE;
      end
    endcase
  end

  // State register; reset leaves no operation running and no protection (erased state is the array's)
  always_ff @(posedge i_sys_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r <= '0; // R10
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_rd_ready     = st_r.rd_ready;
  assign o_rd_seq_hit   = st_r.seq_hit;
  assign o_busy_modules = st_r.busy_mods;
  assign o_busy         = st_r.busy; // Own flop so the output never glitches
  assign o_pe_done      = st_r.done;
  assign o_pe_error     = st_r.error;

  // An accepted erase loads the erase count and raises busy on the next cycle
  erase_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R7
    (st_r.state == FAPC_ST_IDLE && i_pe_req.start && i_pe_req.op == FAPC_OP_ERASE && pe_allowed)
    |=> (st_r.cnt == FAPC_CNT_W'(ERASE_CYC - 1)) && o_busy)
    else $error("erase length wrong");
  prog_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R8
    (st_r.state == FAPC_ST_IDLE && i_pe_req.start && i_pe_req.op == FAPC_OP_PROG && pe_allowed)
    |=> (st_r.cnt == FAPC_CNT_W'(PROG_CYC - 1)) && o_busy)
    else $error("program length wrong");
  no_read_busy_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R4
    (st_r.state == FAPC_ST_IDLE && i_pe_req.start && i_pe_req.op != FAPC_OP_NONE
     && (i_pe_req.modules & rd_mask) != '0)
    |=> !o_busy && o_pe_error)
    else $error("read module started");
  // Code SRAM reads alone must not block a full parallel request
  sram_par_ok_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R5
    (st_r.state == FAPC_ST_IDLE && i_pe_req.start && i_pe_req.op != FAPC_OP_NONE && i_code_sram_rd
     && rd_mask == '0 && i_clk_le_80mhz && i_pe_req.modules != '0) |=> o_busy)
    else $error("parallel refused under sram reads");
  seq_no_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R2
    (i_rd_req.valid && !st_r.rd_wait && rd_seq) |=> o_rd_ready && o_rd_seq_hit)
    else $error("sequential read stalled");
  nonseq_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R2
    (i_rd_req.valid && !st_r.rd_wait && !rd_seq && i_flash_wait_state_count == 4'h4)
    |=> !o_rd_ready [*4] ##1 o_rd_ready)
    else $error("wait count wrong");
  prefetch_addr_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R3
    (i_rd_req.valid && !st_r.rd_wait) |=> st_r.pf_addr == $past(i_rd_req.addr) + FAPC_ADDR_STEP)
    else $error("prefetch address wrong");
  multi_read_one_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R6
    (st_r.state == FAPC_ST_IDLE && i_pe_req.start && rd_cnt > 3'h1 && pe_cnt > 3'h1) |=> !o_busy)
    else $error("parallel under multiple reads");
  tail_done_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // R9
    (st_r.state == FAPC_ST_RUN && st_r.cnt == '0) |-> ##5 o_pe_done)
    else $error("overhead length wrong");

endmodule
`default_nettype wire

// ---- fapc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bus master stand-in that issues one-cycle read requests
module fapc_core_model
  import fapc_pkg::*;
(
  input  wire logic                   i_go,
  input  wire logic [FAPC_MOD_W-1:0]  i_mod,
  input  wire logic [FAPC_ADDR_W-1:0] i_addr,
  output wire fapc_rd_req_t           o_rd_req
);
  // Idle address is inverted so a stale value never looks like a live request
  assign o_rd_req = '{valid: i_go, module_sel: i_mod, addr: i_go ? i_addr : ~i_addr};
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fapc_pkg::*;
  logic                   i_sys_clk;
  logic                   i_sys_rst;
  logic                   le80;
  logic                   go;
  logic                   sram;
  logic [3:0]             ws;
  logic [3:0]             rdm;
  logic [1:0]             mod;
  logic [19:0]            addr;
  fapc_rd_req_t           rq;
  fapc_pe_req_t           pe_r;
  logic                   rdy;
  logic                   hit;
  logic [3:0]             bmods;
  logic                   busy;
  logic                   done;
  logic                   err;
  int                     failures;
  int                     checked;
  int                     cyc;

  fapc_core_model CORE (.i_go(go), .i_mod(mod), .i_addr(addr), .o_rd_req(rq));

  // Short counts keep the run brief; expectations below use the same values
  fapc_ctrl #(.ERASE_CYC(20), .PROG_CYC(10)) DUT (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_flash_wait_state_count(ws),
    .i_clk_le_80mhz(le80), .i_rd_req(rq), .i_code_sram_rd(sram), .i_read_modules(rdm),
    .i_pe_req(pe_r), .o_rd_ready(rdy), .o_rd_seq_hit(hit), .o_busy_modules(bmods),
    .o_busy(busy), .o_pe_done(done), .o_pe_error(err));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic c, input string s);
    checked++;
    if (c !== 1'b1)
    begin
      failures++;
      $display("ERROR %0t: %s", $time, s);
    end
  endtask

  task automatic results;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One read; n is the expected edge count from request to ready
  task automatic rd(input logic [19:0] a, input logic [1:0] m, input int n, input logic h);
    int k;
    addr = a;
    mod  = m;
    go   = 1'b1;
    @(posedge i_sys_clk) #1 go = 1'b0;
    // A prefetch hit pulses ready right after the request edge, so look there first
    k = 1;
    while (rdy !== 1'b1 && k < 40)
    begin
      @(posedge i_sys_clk) #1;
      k++;
    end
    chk(k === n && hit === h, "read latency or hit flag");
    $display("read test done");
  endtask

  // One program/erase start; ok says whether it must be accepted
  task automatic pe(input fapc_op_t op, input logic [3:0] m, rd_set, input logic ok, input int dur);
    int k;
    rdm  = rd_set;
    pe_r = '{start: 1'b1, op: op, modules: m};
    @(posedge i_sys_clk) #1 pe_r.start = 1'b0;
    @(posedge i_sys_clk) #1 k = 1;
    if (ok)
    begin
      // Busy must hold the exact module set until the done pulse
      while (done !== 1'b1 && k < 200)
      begin
        if (bmods !== m) chk(1'b0, "busy set lost");
        @(posedge i_sys_clk) #1 k++;
      end
      chk(k === dur + 4 && busy === 1'b0 && err === 1'b0, "done timing");
    end
    else
      chk(err === 1'b1 && busy === 1'b0, "refused start");
    rdm = 4'h0;
    @(posedge i_sys_clk) #1;
    $display("pe test done");
  endtask

  // Cycle ceiling well above the expected run of under a hundred cycles
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      $display("ERROR %0t: timeout", $time);
      results();
    end
  end

  initial
  begin
    failures = 0;
    checked = 0;
    cyc = 0;
    i_sys_rst = 1'b1;
    le80 = 1'b1;
    go = 1'b0;
    sram = 1'b0;
    ws = 4'h4;
    rdm = 4'h0;
    mod = 2'h0;
    addr = 20'h00000;
    pe_r = '{start: 1'b0, op: FAPC_OP_NONE, modules: 4'h0};
    repeat (4) @(posedge i_sys_clk);
    #1 i_sys_rst = 1'b0;
    chk(!rdy && !hit && bmods == 4'h0 && !busy && !done && !err, "reset state");
    rd(20'h00100, 2'h0, 5, 1'b0);
    rd(20'h00101, 2'h0, 1, 1'b1);
    ws = 4'h5;
    rd(20'h00200, 2'h1, 6, 1'b0);
    // Refusals alternate with accepted starts so the sticky error flag is seen to rise each time
    pe(FAPC_OP_ERASE, 4'h1, 4'h0, 1'b1, 20);
    pe(FAPC_OP_PROG, 4'h2, 4'h2, 1'b0, 0);
    sram = 1'b1;
    pe(FAPC_OP_PROG, 4'hf, 4'h0, 1'b1, 10);
    le80 = 1'b0;
    pe(FAPC_OP_ERASE, 4'h6, 4'h1, 1'b0, 0);
    le80 = 1'b1;
    pe(FAPC_OP_PROG, 4'h8, 4'h3, 1'b1, 10);
    pe(FAPC_OP_ERASE, 4'hc, 4'h3, 1'b0, 0);
    results();
  end
endmodule
`default_nettype wire
